/* File: hdl/motion_command_interface.sv */
// Purpose: Command byte interpreter and motion sequencer for a position module
// Assumes: Host byte, strobe and switch arrive asynchronously; one 100 MHz clock
// Notes:   Speed is pulses per clock cycle x 1/65536; decel is linear, 1 unit per tick
// Contract
// - A 0 to 1 change of the request bit launches a new command.
// - Request dropping to 0 while active aborts; motion decelerates to a stop.
// - After completion, request must return to 0 before a new command.
// - After an abort, no new command until deceleration fully ends.
// - Selector changes are ignored while a command is active.
// - Selectors 0 to 24 run the matching profile block.
// - Selectors 25 to 117 are reserved and report an error.
// - Command 118 asserts drive disable, 119 releases it.
// - Command 120 pulses the clear output; 121 reloads current position.
// - Command 122 runs the interactive block; 123 captures reference offset.
// - 124/125 jog positive/negative, 126 seeks reference, 127 reloads configuration.
// - Host stop with request cleared decelerates any motion to a stop.
// - Host stop with request forced on finishes or starts the selected command.
// - Host stop with request held completes motion in progress.
// - Host clearing all outputs on fatal error decelerates motion to stop.
// - Output watchdog forces commands off on lost host; motion decelerates.
// - Internal fatal error drives both pulses, disable and clear inactive.
// - Profile command behaviour comes from the selected block's mode field.
// - Mode 0 absolute steps; direction from current position versus first target.
// - Mode 1 relative steps; distance sign sets direction.
// - Multi-step modes 0/1 reversing direction are rejected with an error.
// - Modes 2/3 run at first-step speed until the request returns idle.
// - Modes 6/7 run until reference switch, then travel first-step distance.
// - Modes 6/7 with zero distance simply decelerate at the switch.
// - The clear pulse lasts 50 ms.
// - Command 121 loads current position from interactive target position.
// - Done reads 0 while busy and 1 when complete.
`timescale 1ns/1ps
`include "motion_cmd_cfg.svh"

module motion_command_interface
    import motion_cmd_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [7:0]   command_byte,
    input  wire logic         host_write,
    input  wire logic         reference_switch_input,
    input  wire logic         fatal_error,
    input  wire profile_s     profile_block [0:24],
    input  wire profile_s     interactive_block,
    input  wire logic         jog_speed_neg,
    output logic              pulse_output_a,
    output logic              pulse_output_b,
    output logic              drive_disable_output,
    output logic              clear_pulse_output,
    output logic              done,
    output logic [7:0]        error_code,
    output logic signed [31:0] current_position,
    output logic              ref_offset_capture,
    output logic              config_reload,
    output logic              watchdog_expired
);
    localparam logic [22:0] CLR_CYC  = 23'(`CLEAR_PULSE_CYC);
    localparam logic [19:0] WDOG_CYC = 20'(`WDOG_CYC);
    localparam logic [7:0]  DIV_LAST = 8'(`RATE_DIV - 1);

    // Two-stage synchronisers for the command byte, host write, reference switch and fatal error pins
    logic [7:0] cmd_m, cmd_q;
    logic [2:0] pin_m, pin_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_m <= 8'h00;
            cmd_q <= 8'h00;
            pin_m <= 3'h0;
            pin_q <= 3'h0;
        end else begin
            cmd_m <= command_byte;
            cmd_q <= cmd_m;
            pin_m <= {host_write, reference_switch_input, fatal_error};
            pin_q <= pin_m;
        end
    end

    state_s s, next_s;
    cmd_s   cmd;
    logic   wr_sync, ref_sw, fatal;
    logic   req_eff, launch, tick, at_goal;
    logic [6:0] sel_now;
    profile_s blk;

    function automatic step_s pick_step(input profile_s p, input logic [1:0] i);
        case (i)
            2'd0:    pick_step = p.step0;
            2'd1:    pick_step = p.step1;
            2'd2:    pick_step = p.step2;
            default: pick_step = p.step3;
        endcase
    endfunction : pick_step

    // Direction of a step: sign of relative distance or of absolute displacement
    function automatic logic step_neg(input logic [3:0] mode, input step_s st,
                                      input logic signed [31:0] from);
        if (mode == `MODE_REL)
            step_neg = st.pos[31];
        else
            step_neg = (st.pos < from);
    endfunction : step_neg

    // A reversal check across up to four steps; each step starts where the last ended
    function automatic logic reverses(input profile_s p, input logic signed [31:0] from);
        logic               first_neg;
        logic signed [31:0] at;
        step_s              st;
        reverses = 1'b0;
        st = p.step0;
        first_neg = step_neg(p.mode, st, from);
        at = (p.mode == `MODE_REL) ? from + st.pos : st.pos;
        for (int i = 1; i < 4; i++) begin
            st = pick_step(p, 2'(i));
            if (2'(i) <= p.last_step) begin
                if (step_neg(p.mode, st, at) != first_neg
                    && ((p.mode == `MODE_REL) ? (st.pos != 32'sh0) : (st.pos != at)))
                    reverses = 1'b1;
                at = (p.mode == `MODE_REL) ? at + st.pos : st.pos;
            end
        end
    endfunction : reverses

    assign cmd     = cmd_s'(cmd_q);
    assign wr_sync = pin_q[2];
    assign ref_sw  = pin_q[1];
    assign fatal   = pin_q[0];
    // A lost host reads as an all-off output byte
    assign req_eff = cmd.req && !s.wd_expired;
    assign launch  = req_eff && !s.req_prev;
    assign tick    = (s.div == DIV_LAST);
    // Selector is frozen at launch so later host changes cannot steer the motion
    assign sel_now = (s.seq == ST_IDLE) ? cmd.sel : s.sel;
    assign blk     = (sel_now == `SEL_INTERACTIVE || sel_now == `SEL_SEEK_REF)
                   ? interactive_block
                   : profile_block[(sel_now <= `SEL_LAST_PROFILE) ? sel_now[4:0] : 5'd0];
    assign at_goal = !s.cont && (!s.trig || s.armed) && (s.cur_pos == s.target);

    always_comb begin
        step_s              st;
        logic signed [31:0] remain;
        logic [16:0]        acc_sum;
        next_s = s;
        st = pick_step(blk, 2'd0);
        remain = 32'sh0;
        acc_sum = 17'h0;
        next_s.req_prev = req_eff;
        next_s.ref_offset_cap = 1'b0;
        next_s.cfg_reload = 1'b0;
        next_s.div = tick ? 8'h00 : s.div + 8'h01;
        // Host writes refresh the watchdog; silence trips it
        if (wr_sync) begin
            next_s.wdog = 20'h0;
            next_s.wd_expired = 1'b0;
        end else if (s.wdog == WDOG_CYC) begin
            next_s.wd_expired = 1'b1;
        end else begin
            next_s.wdog = s.wdog + 20'h1;
        end
        if (s.clr_cnt != 23'h0)
            next_s.clr_cnt = s.clr_cnt - 23'h1;

        case (s.seq)
            ST_IDLE: begin
                // Selector is sampled only at launch, so later changes do nothing
                if (launch) begin
                    next_s.err = `ERR_NONE;
                    next_s.done = 1'b0;
                    next_s.seq = ST_WAIT_IDLE;
                    next_s.sel = cmd.sel;
                    if (cmd.sel <= `SEL_LAST_PROFILE || cmd.sel == `SEL_INTERACTIVE) begin
                        next_s.step_idx = 2'd0;
                        next_s.last_step = blk.last_step;
                        next_s.goal_speed = st.speed;
                        next_s.armed = 1'b0;
                        next_s.cont = 1'b0;
                        next_s.trig = 1'b0;
                        next_s.seq = ST_RUN;
                        case (blk.mode)
                            `MODE_ABS, `MODE_REL: begin
                                next_s.dir_neg = step_neg(blk.mode, st, s.cur_pos);
                                next_s.target = (blk.mode == `MODE_REL) ? s.cur_pos + st.pos
                                                                         : st.pos;
                                if (blk.last_step != 2'd0 && reverses(blk, s.cur_pos)) begin
                                    next_s.err = `ERR_REVERSAL;
                                    next_s.seq = ST_WAIT_IDLE;
                                    next_s.done = 1'b1;
                                end
                            end
                            `MODE_CONT_POS, `MODE_CONT_NEG: begin
                                next_s.cont = 1'b1;
                                next_s.dir_neg = (blk.mode == `MODE_CONT_NEG);
                            end
                            `MODE_TRIG_POS, `MODE_TRIG_NEG: begin
                                next_s.trig = 1'b1;
                                next_s.dir_neg = (blk.mode == `MODE_TRIG_NEG);
                            end
                            default: begin
                                next_s.err = `ERR_BAD_MODE;
                                next_s.seq = ST_WAIT_IDLE;
                                next_s.done = 1'b1;
                            end
                        endcase
                    end else if (cmd.sel >= `SEL_JOG_POS && cmd.sel <= `SEL_SEEK_REF) begin
                        // Jog runs until idle; seek runs toward the switch, then travels the interactive first-step distance
                        next_s.goal_speed = interactive_block.step0.speed;
                        next_s.dir_neg = (cmd.sel == `SEL_JOG_NEG) ||
                                         (cmd.sel == `SEL_SEEK_REF && jog_speed_neg);
                        next_s.cont = (cmd.sel != `SEL_SEEK_REF);
                        next_s.trig = (cmd.sel == `SEL_SEEK_REF);
                        next_s.armed = 1'b0;
                        next_s.target = s.cur_pos;
                        next_s.last_step = 2'd0;
                        next_s.seq = ST_RUN;
                    end else begin
                        next_s.done = 1'b1;
                        case (cmd.sel)
                            `SEL_DIS_ON:     next_s.dis = 1'b1;
                            `SEL_DIS_OFF:    next_s.dis = 1'b0;
                            `SEL_CLEAR:      next_s.clr_cnt = CLR_CYC;
                            `SEL_RELOAD_POS: next_s.cur_pos = interactive_block.step0.pos;
                            `SEL_CAPTURE_REF: next_s.ref_offset_cap = 1'b1;
                            `SEL_RELOAD_CFG: next_s.cfg_reload = 1'b1;
                            default:         next_s.err = `ERR_RESERVED;
                        endcase
                    end
                end
            end
            ST_RUN: begin
                // Request dropped (host stop or host clearing outputs, watchdog) aborts with decel
                if (!req_eff) begin
                    next_s.seq = ST_DECEL;
                end else begin
                    // Held request keeps running to completion
                    if (s.speed < s.goal_speed && tick)
                        next_s.speed = s.speed + 16'h1;
                    else if (s.speed > s.goal_speed && tick)
                        next_s.speed = s.speed - 16'h1;
                    if (s.trig && !s.armed && ref_sw) begin
                        next_s.armed = 1'b1;
                        remain = st.pos;
                        if (remain == 32'sh0) begin
                            next_s.seq = ST_DECEL;
                        end else begin
                            next_s.target = s.dir_neg ? s.cur_pos - remain
                                                      : s.cur_pos + remain;
                        end
                    end
                    if (at_goal) begin
                        if (s.step_idx == s.last_step || s.trig) begin
                            next_s.speed = 16'h0;
                            next_s.seq = ST_WAIT_IDLE;
                            next_s.done = 1'b1;
                        end else begin
                            st = pick_step(blk, s.step_idx + 2'd1);
                            next_s.step_idx = s.step_idx + 2'd1;
                            next_s.goal_speed = st.speed;
                            next_s.target = (blk.mode == `MODE_REL) ? s.cur_pos + st.pos
                                                                     : st.pos;
                        end
                    end
                end
            end
            ST_DECEL: begin
                if (s.speed == 16'h0) begin
                    // New commands wait until the stop is complete
                    next_s.seq = ST_WAIT_IDLE;
                    next_s.done = 1'b1;
                end else if (tick) begin
                    next_s.speed = s.speed - 16'h1;
                end
            end
            ST_WAIT_IDLE: begin
                if (!req_eff)
                    next_s.seq = ST_IDLE;
            end
            default: next_s.seq = ST_IDLE;
        endcase

        // Pulse generation: accumulate speed each cycle while moving
        // No pulse on the arrival cycle, otherwise the axis overshoots by one
        if ((s.seq == ST_RUN && !at_goal) || s.seq == ST_DECEL) begin
            acc_sum = {1'b0, s.acc} + {1'b0, s.speed};
            next_s.acc = acc_sum[15:0];
            next_s.pa = acc_sum[16];
            next_s.pb = s.dir_neg;
            if (acc_sum[16])
                next_s.cur_pos = s.dir_neg ? s.cur_pos - 32'sh1 : s.cur_pos + 32'sh1;
        end else begin
            next_s.pa = 1'b0;
        end

        // Internal fatal error kills all drive outputs and motion
        if (fatal) begin
            next_s.pa = 1'b0;
            next_s.pb = 1'b0;
            next_s.dis = 1'b0;
            next_s.clr_cnt = 23'h0;
            next_s.speed = 16'h0;
            next_s.seq = ST_WAIT_IDLE;
            next_s.done = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.seq <= ST_IDLE;
            s.done <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign pulse_output_a       = s.pa;
    assign pulse_output_b       = s.pb;
    assign drive_disable_output = s.dis;
    assign clear_pulse_output   = (s.clr_cnt != 23'h0);
    assign done                 = s.done;
    assign error_code           = s.err;
    assign current_position     = s.cur_pos;
    assign ref_offset_capture   = s.ref_offset_cap;
    assign config_reload        = s.cfg_reload;
    assign watchdog_expired     = s.wd_expired;

    dis_on_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_IDLE && launch && cmd.sel == `SEL_DIS_ON && !fatal) |=> drive_disable_output)
        else $error("disable not asserted by command");
    dis_off_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_IDLE && launch && cmd.sel == `SEL_DIS_OFF) |=> !drive_disable_output)
        else $error("disable not released by command");
    clr_start_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_IDLE && launch && cmd.sel == `SEL_CLEAR && !fatal) |=> clear_pulse_output [*8])
        else $error("clear pulse not started");
    reserved_err_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_IDLE && launch && cmd.sel > `SEL_LAST_PROFILE
         && cmd.sel <= `SEL_LAST_RESERVED && !fatal) |=> (error_code == `ERR_RESERVED && done))
        else $error("reserved selector not flagged");
    abort_decel_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_RUN && !req_eff && !fatal) |=> s.seq == ST_DECEL)
        else $error("abort did not decelerate");
    no_relaunch_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_WAIT_IDLE && req_eff) |=> s.seq != ST_RUN)
        else $error("command accepted without idle");
    decel_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_DECEL && s.speed != 16'h0 && !fatal) |=> s.seq == ST_DECEL)
        else $error("left deceleration early");
    fatal_off_a: assert property (@(posedge clk) disable iff (!rstn)
        fatal |=> (!pulse_output_a && !pulse_output_b && !drive_disable_output
                   && !clear_pulse_output))
        else $error("outputs live after internal fault");
    busy_done_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_RUN || s.seq == ST_DECEL) |-> !done)
        else $error("done high while busy");
    reload_pos_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_IDLE && launch && cmd.sel == `SEL_RELOAD_POS && !fatal)
        |=> current_position == $past(interactive_block.step0.pos))
        else $error("position reload mismatch");
    // Arrival at the last target ends the command with no further pulse
    goal_done_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_RUN && req_eff && at_goal && (s.step_idx == s.last_step || s.trig)
         && !fatal) |=> (done && !pulse_output_a))
        else $error("target reached without done");
    idle_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        (s.seq == ST_IDLE || s.seq == ST_WAIT_IDLE) |=> !pulse_output_a)
        else $error("step pulse while stopped");
    sequence ref_hit_s;
        s.seq == ST_RUN && req_eff && s.trig && !s.armed && ref_sw && !fatal;
    endsequence
    trig_arm_a: assert property (@(posedge clk) disable iff (!rstn)
        ref_hit_s |=> s.armed)
        else $error("switch did not arm the stop");
endmodule : motion_command_interface

/* File: hdl/motion_cmd_cfg.svh */
// Purpose: Constants for the motion command interface
// Assumes: 100 MHz clock
// Notes:   Selector codes, field positions, timing counts, error and mode codes
`ifndef MOTION_CMD_CFG_SVH
`define MOTION_CMD_CFG_SVH
`define REQ_BIT            7
`define SEL_LAST_PROFILE   7'h18
`define SEL_LAST_RESERVED  7'h75
`define SEL_DIS_ON         7'h76
`define SEL_DIS_OFF        7'h77
`define SEL_CLEAR          7'h78
`define SEL_RELOAD_POS     7'h79
`define SEL_INTERACTIVE    7'h7A
`define SEL_CAPTURE_REF    7'h7B
`define SEL_JOG_POS        7'h7C
`define SEL_JOG_NEG        7'h7D
`define SEL_SEEK_REF       7'h7E
`define SEL_RELOAD_CFG     7'h7F
`define CLK_MHZ            100
`define CLEAR_PULSE_MS     50
`define CLEAR_PULSE_CYC    (`CLEAR_PULSE_MS * 1000 * `CLK_MHZ)
`define WDOG_CYC           1000000
`define RATE_DIV           100
`define ERR_NONE           8'h00
`define ERR_RESERVED       8'h01
`define ERR_REVERSAL       8'h02
`define ERR_BAD_MODE       8'h03
`define MODE_ABS           4'h0
`define MODE_REL           4'h1
`define MODE_CONT_POS      4'h2
`define MODE_CONT_NEG      4'h3
`define MODE_TRIG_POS      4'h6
`define MODE_TRIG_NEG      4'h7
`endif

/* File: hdl/motion_cmd_pkg.sv */
// Purpose: Types for the motion command interface
// Assumes: Constants come from motion_cmd_cfg.svh
// Notes:   A profile step holds a signed position and an unsigned speed
package motion_cmd_pkg;
    typedef struct packed {
        logic signed [31:0] pos;
        logic [15:0]        speed;
    } step_s;

    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] last_step;
        step_s      step0;
        step_s      step1;
        step_s      step2;
        step_s      step3;
    } profile_s;

    typedef struct packed {
        logic       req;
        logic [6:0] sel;
    } cmd_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_DECEL,
        ST_WAIT_IDLE
    } seq_e;

    typedef struct packed {
        seq_e               seq;
        logic [6:0]         sel;
        logic               req_prev;
        logic               dir_neg;
        logic               cont;
        logic               trig;
        logic               armed;
        logic [1:0]         step_idx;
        logic [1:0]         last_step;
        logic signed [31:0] target;
        logic signed [31:0] cur_pos;
        logic [15:0]        speed;
        logic [15:0]        goal_speed;
        logic [7:0]         div;
        logic [15:0]        acc;
        logic [22:0]        clr_cnt;
        logic [19:0]        wdog;
        logic               wd_expired;
        logic               done;
        logic [7:0]         err;
        logic               dis;
        logic               pa;
        logic               pb;
        logic               ref_offset_cap;
        logic               cfg_reload;
    } state_s;
endpackage : motion_cmd_pkg

/* File: verification/host_model.sv */
// Purpose: Host controller model that writes the command byte
// Assumes: Byte changes 1 ns after a rising edge and then holds
// Notes:   Activity line toggles every cycle so the watchdog stays fed
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk,
    output logic [7:0]      command_byte,
    output logic            host_write
);
    initial begin
        command_byte = 8'h00;
        host_write   = 1'b0;
    end

    always @(posedge clk) host_write <= #1 ~host_write;

    // Hold a byte for n edges, then step past the edge to let outputs settle
    task automatic put(input logic [7:0] b, input int n);
        @(posedge clk);
        #1 command_byte = b;
        repeat (n) @(posedge clk);
        #2;
    endtask : put

    // Idle first so every launch shows a fresh 0 to 1 request edge
    task automatic launch(input logic [6:0] sel);
        put(8'h00, 4);
        put({1'b1, sel}, 6);
    endtask : launch
endmodule : host_model

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the motion command interface
// Assumes: Seeded random selectors and positions; 100 MHz clock
// Notes:   Clear pulse and watchdog counts are too long to run out here
`timescale 1ns/1ps
`include "motion_cmd_cfg.svh"
module tb_top;
    import motion_cmd_pkg::*;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic [7:0]         cbyte;
    logic               hw, ref_sw, fatal, jog_neg;
    profile_s           prof [0:24];
    profile_s           inter;
    logic               pa, pb, dis, clr, done, cap, rl, wd;
    logic [7:0]         err;
    logic signed [31:0] pos;
    int                 bad_count = 0, total_checks = 0, seed = 69588, caps = 0, rls = 0;
    int                 pulses = 0;

    always #5 clk = ~clk;
    // Counted mid-cycle so registered pulses are settled
    always @(negedge clk) begin
        caps   += int'(cap);
        rls    += int'(rl);
        pulses += int'(pa);
    end

    host_model host_model_i (.clk(clk), .command_byte(cbyte), .host_write(hw));
    motion_command_interface motion_command_interface_i (
        .clk(clk), .rstn(rstn), .command_byte(cbyte), .host_write(hw),
        .reference_switch_input(ref_sw), .fatal_error(fatal), .profile_block(prof),
        .interactive_block(inter), .jog_speed_neg(jog_neg), .pulse_output_a(pa),
        .pulse_output_b(pb), .drive_disable_output(dis), .clear_pulse_output(clr),
        .done(done), .error_code(err), .current_position(pos),
        .ref_offset_capture(cap), .config_reload(rl), .watchdog_expired(wd));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic wait_done(input int lim);
        int k;
        for (k = 0; k < lim && done !== 1'b1; k++) @(posedge clk);
        #2;
        if (k == lim) begin
            bad_count++;
            $display("FAIL %0t done never returned", $time);
            end_sim();
        end
    endtask : wait_done

    initial begin
        int         i;
        logic [6:0] r;
        logic       xneg;
        ref_sw  = 1'b0;
        fatal   = 1'b0;
        jog_neg = 1'b0;
        for (i = 0; i < 25; i++) prof[i] = '0;
        inter = '0;
        inter.step0.pos = $random(seed);
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        chk(32'(done), 32'h1, "done after reset");
        chk(32'(wd), 32'h0, "watchdog while fed");
        host_model_i.launch(`SEL_DIS_ON);
        chk(32'(dis), 32'h1, "disable on");
        host_model_i.put({1'b1, `SEL_DIS_OFF}, 6);
        chk(32'(dis), 32'h1, "selector change ignored");
        host_model_i.launch(`SEL_DIS_OFF);
        chk(32'(dis), 32'h0, "disable off");
        $display("test disable finished");
        for (i = 0; i < 5; i++) begin
            r = (i == 0) ? 7'h19 : (i == 1) ? 7'h75 : 7'h19 + 7'($unsigned($random(seed)) % 93);
            host_model_i.launch(r);
            chk(32'(err), 32'(`ERR_RESERVED), "reserved selector");
        end
        host_model_i.launch(`SEL_RELOAD_POS);
        chk(32'(pos), 32'(inter.step0.pos), "position reload");
        host_model_i.launch(`SEL_CAPTURE_REF);
        host_model_i.launch(`SEL_RELOAD_CFG);
        chk(32'(caps), 32'h1, "capture pulse");
        chk(32'(rls), 32'h1, "reload pulse");
        $display("test immediate commands finished");
        prof[3].mode      = `MODE_REL;
        prof[3].last_step = 2'h1;
        prof[3].step0.pos = 32'sd10;
        prof[3].step1.pos = -32'sd10;
        host_model_i.launch(7'h03);
        chk(32'(err), 32'(`ERR_REVERSAL), "reversal refused");
        prof[4].mode        = `MODE_CONT_POS;
        prof[4].step0.speed = 16'hFFFF;
        host_model_i.launch(7'h04);
        repeat (3000) @(posedge clk);
        #1 chk(32'(done), 32'h0, "busy while running");
        chk(32'(pb), 32'h0, "positive direction");
        host_model_i.put(8'h00, 3);
        host_model_i.put({1'b1, `SEL_DIS_ON}, 6);
        chk(32'(dis), 32'h0, "refused during decel");
        host_model_i.put(8'h00, 2);
        wait_done(20000);
        host_model_i.launch(`SEL_DIS_ON);
        chk(32'(dis), 32'h1, "accepted after decel");
        $display("test abort finished");
        prof[7].mode = 4'h4;
        host_model_i.launch(7'h07);
        chk(32'(err), 32'(`ERR_BAD_MODE), "unsupported mode");
        inter.step0.speed = 16'hFFFF;
        host_model_i.launch(`SEL_JOG_NEG);
        repeat (2000) @(posedge clk);
        #1 chk(32'(pb), 32'h1, "jog negative");
        host_model_i.put(8'h00, 2);
        wait_done(20000);
        prof[5].mode        = `MODE_ABS;
        prof[5].step0.speed = 16'hFFFF;
        prof[5].step0.pos   = (pos < 0) ? pos + 32'sd20 : pos - 32'sd20;
        xneg = (pos >= 0);
        i = pulses;
        host_model_i.launch(7'h05);
        wait_done(30000);
        chk(32'(pos), 32'(prof[5].step0.pos), "absolute target");
        chk(32'(pb), 32'(xneg), "absolute direction");
        chk(32'(pulses - i), 32'd20, "step pulses");
        prof[6].mode        = `MODE_TRIG_POS;
        prof[6].step0.speed = 16'hFFFF;
        prof[6].step0.pos   = 32'sd5;
        host_model_i.launch(7'h06);
        repeat (3000) @(posedge clk);
        #1 ref_sw = 1'b1;
        repeat (2) @(posedge clk);
        #1 i = pos;
        wait_done(30000);
        chk(32'(pos), 32'(i + 5), "travel after switch");
        ref_sw = 1'b0;
        $display("test profiles finished");
        host_model_i.launch(`SEL_CLEAR);
        repeat (2000) @(posedge clk);
        #1 chk(32'(clr), 32'h1, "clear still high");
        fatal = 1'b1;
        repeat (5) @(posedge clk);
        #2;
        chk(32'({pa, pb, dis, clr}), 32'h0, "outputs off on fault");
        fatal = 1'b0;
        $display("test fault finished");
        end_sim();
    end
endmodule : tb_top
